// ---- hw/mrp_defines.svh ----
// offsets, field positions, reset values and encodings of the region protection unit
`ifndef MRP_DEFINES_SVH
`define MRP_DEFINES_SVH
// region count and selector width
`define MRP_NUM_REGIONS 8
`define MRP_SEL_W 3
// register byte offsets
`define MRP_ADR_CTRL 8'h00
`define MRP_ADR_COUNT 8'h04
`define MRP_ADR_SEL 8'h08
`define MRP_ADR_BASE 8'h0C
`define MRP_ADR_ATTR 8'h10
`define MRP_ADR_REN 8'h14
`define MRP_ADR_FSTAT 8'h18
`define MRP_ADR_FADDR 8'h1C
// control bits
`define MRP_CTRL_EN 0
`define MRP_CTRL_PRIVDEF 1
`define MRP_CTRL_HFNMI 2
// attribute fields
`define MRP_ATTR_EN 0
`define MRP_ATTR_SZ_HI 5
`define MRP_ATTR_SZ_LO 1
`define MRP_ATTR_SRD_HI 15
`define MRP_ATTR_SRD_LO 8
`define MRP_ATTR_AP_HI 26
`define MRP_ATTR_AP_LO 24
`define MRP_ATTR_XN 28
// base field lowest bit (32 byte granule)
`define MRP_BASE_LO 5
// size field: region bytes = 2 ** (field + 1)
`define MRP_SIZE_MIN 5'h04
`define MRP_SIZE_MAX 5'h1F
`define MRP_SUBRGN_MIN 5'h07
// permission encodings
`define MRP_AP_NONE 3'h0
`define MRP_AP_PRW_UNO 3'h1
`define MRP_AP_PRW_URO 3'h2
`define MRP_AP_RW_RW 3'h3
`define MRP_AP_PRO_UNO 3'h5
`define MRP_AP_RO_RO 3'h6
// reset value of every register except COUNT and the size field of ATTR
`define MRP_RST_VAL 32'h00000000
`endif

// ---- hw/mrp_perm_check.sv ----
// permission check of one access against one region's attributes
`timescale 1ns/100ps
module mrp_perm_check
    import mrp_pkg::*;
(
    input wire logic [2:0] ap_i,
    input wire logic xn_i,
    input wire mrp_acc_type acc_type_i,
    input wire logic priv_i,
    output logic allowed_o
);
    logic rd_ok; // reading allowed in the current mode
    logic wr_ok; // writing allowed in the current mode
    // decode the six permission choices; other codes give no access
    always_comb begin
        rd_ok = 1'b0;
        wr_ok = 1'b0;
        case (ap_i)
            `MRP_AP_PRW_UNO: begin
                rd_ok = priv_i;
                wr_ok = priv_i;
            end
            `MRP_AP_PRW_URO: begin
                rd_ok = 1'b1;
                wr_ok = priv_i;
            end
            `MRP_AP_RW_RW: begin
                rd_ok = 1'b1;
                wr_ok = 1'b1;
            end
            `MRP_AP_PRO_UNO: begin
                rd_ok = priv_i;
            end
            `MRP_AP_RO_RO: begin
                rd_ok = 1'b1;
            end
            default: begin
                rd_ok = 1'b0;
            end
        endcase
        // a fetch also needs read access
        case (acc_type_i)
            MRP_ACC_FETCH: allowed_o = rd_ok && !xn_i;
            MRP_ACC_READ: allowed_o = rd_ok;
            MRP_ACC_WRITE: allowed_o = wr_ok;
            default: allowed_o = 1'b0;
        endcase
    end
endmodule

// ---- hw/mrp_pkg.sv ----
// types shared by the region protection unit
package mrp_pkg;
`include "mrp_defines.svh"
    // kind of memory access presented by the core
    typedef enum logic [1:0] {
        MRP_ACC_FETCH,
        MRP_ACC_READ,
        MRP_ACC_WRITE,
        MRP_ACC_RSVD
    } mrp_acc_type;
    // complete state of the unit; size holds field minus the minimum
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        logic glb_en;
        logic priv_def;
        logic hf_nmi;
        logic [`MRP_SEL_W-1:0] sel;
        logic [`MRP_NUM_REGIONS-1:0] ren;
        logic [`MRP_NUM_REGIONS-1:0][26:0] base;
        logic [`MRP_NUM_REGIONS-1:0][4:0] size;
        logic [`MRP_NUM_REGIONS-1:0][7:0] srd;
        logic [`MRP_NUM_REGIONS-1:0][2:0] ap;
        logic [`MRP_NUM_REGIONS-1:0] xn;
        logic fault;
        logic [31:0] faddr;
    } mrp_state_type;
endpackage

// ---- hw/mrp_region_match.sv ----
// address match of one protection region, sub-region holes included
`timescale 1ns/100ps
module mrp_region_match (
    input wire logic [31:0] addr_i,
    input wire logic [26:0] base_i,
    input wire logic [4:0] size_i,
    input wire logic [7:0] srd_i,
    input wire logic en_i,
    output logic hit_o
);
    logic [32:0] span; // region length in bytes
    logic [31:0] mask; // address bits compared with the base
    logic [31:0] shifted; // address moved down to the sub-region index
    logic in_range; // address lies inside the aligned block
    logic srd_act; // region large enough for sub-regions
    // match is combinational so the check lands in the access cycle
    always_comb begin
        span = 33'h000000001 << ({1'b0, size_i} + 6'h01);
        mask = ~(span[31:0] - 32'h00000001);
        if (span[32]) begin
            mask = 32'h00000000;
        end
        // low base bits are ignored, so the base acts as aligned
        in_range = ((addr_i ^ {base_i, 5'h00}) & mask) == 32'h00000000;
        shifted = addr_i >> (size_i - 5'h02);
        srd_act = size_i >= `MRP_SUBRGN_MIN;
        hit_o = en_i && in_range && !(srd_act && srd_i[shifted[2:0]]);
    end
endmodule

// ---- hw/mrp_top.sv ----
// region protection unit: wishbone registers, region match and fault check
//
// Function
// - up to eight regions, each fully separate
// - sizes power of two, 32 bytes to 4GB
// - fetch from no-execute region is violation
// - no, read-only or read/write per mode
// - every region has eight sub-region disables
// - disabled sub-region leaves hole in region
// - violation while enabled raises management fault
// - region disable keeps base, size, attributes
// - attribute readback carries region enable bit
// - privileged default map covers unmatched privileged access
// - no enabled region without default faults
// - handler option decides protection in handlers
// - global enable clear means no faults
// - region count readable regardless of programming
// - region checked only while enable set
// - sub-regions act only from 256 bytes
// - six permission combinations are encoded
//
// The register offsets and register access over Wishbone were chosen for this implementation.
`timescale 1ns/100ps
module mrp_top
    import mrp_pkg::*;
#(
    parameter int REGIONS = `MRP_NUM_REGIONS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic acc_valid_i,
    input wire logic [31:0] acc_addr_i,
    input wire mrp_acc_type acc_type_i,
    input wire logic acc_priv_i,
    input wire logic acc_handler_i,
    output logic acc_fault_o,
    output logic acc_default_o
);
    localparam int NR = `MRP_NUM_REGIONS;

    mrp_state_type st_r; // registered state
    mrp_state_type st_nxt; // next state

    logic [NR-1:0] hit; // per-region match
    logic any_hit; // some enabled region matches
    logic [`MRP_SEL_W-1:0] hit_idx; // deciding region
    logic allowed; // deciding region permits access
    logic bypass; // protection off for this access
    logic req; // bus request present
    logic wr; // write takes effect at this edge
    logic [7:0] adr; // word aligned register address
    logic sel_ok; // selector points at a real region
    logic [31:0] rd_val; // value of addressed register
    logic [31:0] wmerge; // write data merged under byte enables

    // merge write data into old value under byte enables
    function automatic logic [31:0] wb_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[8*b+:8] = nw[8*b+:8];
            end
        end
        return res;
    endfunction

    // size field to stored code, clamped into the legal range
    function automatic logic [4:0] size_code(input logic [4:0] f);
        logic [4:0] c;
        c = 5'h00;
        if (f > `MRP_SIZE_MIN) begin
            c = f - `MRP_SIZE_MIN;
        end
        return c;
    endfunction

    // one matcher per implemented region
    // up to eight regions
    generate
        for (genvar g = 0; g < NR; g++) begin : g_rgn
            if (g < REGIONS) begin : g_impl
                mrp_region_match u_match (
                    .addr_i(acc_addr_i),
                    .base_i(st_r.base[g]),
                    .size_i(st_r.size[g] + `MRP_SIZE_MIN),
                    .srd_i(st_r.srd[g]),
                    .en_i(st_r.ren[g]),
                    .hit_o(hit[g])
                );
            end else begin : g_none
                assign hit[g] = 1'b0;
            end
        end
    endgenerate

    // pick the highest-numbered matching region
    always_comb begin
        any_hit = 1'b0;
        hit_idx = '0;
        for (int i = 0; i < NR; i++) begin
            if (hit[i]) begin
                any_hit = 1'b1;
                hit_idx = i[`MRP_SEL_W-1:0];
            end
        end
    end

    // permission of the deciding region
    // permission decode
    mrp_perm_check u_perm (
        .ap_i(st_r.ap[hit_idx]),
        .xn_i(st_r.xn[hit_idx]),
        .acc_type_i(acc_type_i),
        .priv_i(acc_priv_i),
        .allowed_o(allowed)
    );

    // fault decision in the access cycle
    always_comb begin
        // bypass when off or in handlers with the handler option clear
        bypass = !st_r.glb_en || (acc_handler_i && !st_r.hf_nmi);
        acc_default_o = bypass || (!any_hit && acc_priv_i && st_r.priv_def);
        acc_fault_o = acc_valid_i && !acc_default_o && (!any_hit || !allowed);
    end

    // register read multiplexer
    always_comb begin
        adr = {wb_adr_i[7:2], 2'h0};
        sel_ok = int'(st_r.sel) < REGIONS;
        rd_val = `MRP_RST_VAL;
        case (adr)
            `MRP_ADR_CTRL: begin
                rd_val[`MRP_CTRL_EN] = st_r.glb_en;
                rd_val[`MRP_CTRL_PRIVDEF] = st_r.priv_def;
                rd_val[`MRP_CTRL_HFNMI] = st_r.hf_nmi;
            end
            `MRP_ADR_COUNT: rd_val = 32'(REGIONS);
            `MRP_ADR_SEL: rd_val[`MRP_SEL_W-1:0] = st_r.sel;
            `MRP_ADR_BASE: begin
                if (sel_ok) begin
                    rd_val = {st_r.base[st_r.sel], 5'h00};
                end
            end
            `MRP_ADR_ATTR: begin
                if (sel_ok) begin
                    rd_val[`MRP_ATTR_EN] = st_r.ren[st_r.sel];
                    rd_val[`MRP_ATTR_SZ_HI:`MRP_ATTR_SZ_LO] = st_r.size[st_r.sel]
                        + `MRP_SIZE_MIN;
                    rd_val[`MRP_ATTR_SRD_HI:`MRP_ATTR_SRD_LO] = st_r.srd[st_r.sel];
                    rd_val[`MRP_ATTR_AP_HI:`MRP_ATTR_AP_LO] = st_r.ap[st_r.sel];
                    rd_val[`MRP_ATTR_XN] = st_r.xn[st_r.sel];
                end
            end
            `MRP_ADR_REN: rd_val[NR-1:0] = st_r.ren;
            `MRP_ADR_FSTAT: rd_val[0] = st_r.fault;
            `MRP_ADR_FADDR: rd_val = st_r.faddr;
            // unmapped addresses read zero
            default: rd_val = `MRP_RST_VAL;
        endcase
    end

    // next state: bus handshake, register writes, fault capture
    always_comb begin
        st_nxt = st_r;
        req = wb_cyc_i && wb_stb_i;
        // ack one cycle after the request, then drop
        st_nxt.ack = req && !st_r.ack;
        if (req && !st_r.ack) begin
            st_nxt.dat = rd_val;
        end
        // writes land at the edge where the master sees ack
        wr = req && st_r.ack && wb_we_i;
        wmerge = wb_merge(rd_val, wb_dat_i, wb_sel_i);
        if (wr) begin
            case (adr)
                `MRP_ADR_CTRL: begin
                    st_nxt.glb_en = wmerge[`MRP_CTRL_EN];
                    st_nxt.priv_def = wmerge[`MRP_CTRL_PRIVDEF];
                    st_nxt.hf_nmi = wmerge[`MRP_CTRL_HFNMI];
                end
                `MRP_ADR_SEL: st_nxt.sel = wmerge[`MRP_SEL_W-1:0];
                `MRP_ADR_BASE: begin
                    if (sel_ok) begin
                        // base kept as written, masked at match
                        st_nxt.base[st_r.sel] = wmerge[31:`MRP_BASE_LO];
                    end
                end
                `MRP_ADR_ATTR: begin
                    if (sel_ok) begin
                        st_nxt.ren[st_r.sel] = wmerge[`MRP_ATTR_EN];
                        st_nxt.size[st_r.sel] =
                            size_code(wmerge[`MRP_ATTR_SZ_HI:`MRP_ATTR_SZ_LO]);
                        st_nxt.srd[st_r.sel] = wmerge[`MRP_ATTR_SRD_HI:`MRP_ATTR_SRD_LO];
                        st_nxt.ap[st_r.sel] = wmerge[`MRP_ATTR_AP_HI:`MRP_ATTR_AP_LO];
                        st_nxt.xn[st_r.sel] = wmerge[`MRP_ATTR_XN];
                    end
                end
                `MRP_ADR_REN: begin
                    for (int i = 0; i < NR; i++) begin
                        if (i < REGIONS) begin
                            st_nxt.ren[i] = wmerge[i];
                        end
                    end
                end
                `MRP_ADR_FSTAT: begin
                    if (wmerge[0]) begin
                        st_nxt.fault = 1'b0;
                    end
                end
                // read-only and unmapped writes ignored
                default: st_nxt.fault = st_nxt.fault;
            endcase
        end
        // new fault wins over a clear in the same cycle
        if (acc_fault_o) begin
            st_nxt.fault = 1'b1;
            st_nxt.faddr = acc_addr_i;
        end
    end

    // state register with clock enable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    // bus outputs straight from flops
    assign wb_ack_o = st_r.ack;
    assign wb_dat_o = st_r.dat;

    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    off_no_fault_a: assert property (!st_r.glb_en |-> !acc_fault_o)
        else $error("fault while unit disabled");
    handler_bypass_a: assert property (acc_handler_i && !st_r.hf_nmi |-> !acc_fault_o)
        else $error("fault inside handler with bypass");
    handler_keep_a: assert property (acc_valid_i && st_r.glb_en && acc_handler_i
        && st_r.hf_nmi && st_r.ren == '0 && !(acc_priv_i && st_r.priv_def) |-> acc_fault_o)
        else $error("handler protection not applied");
    priv_default_a: assert property (st_r.glb_en && acc_priv_i && st_r.priv_def
        && !any_hit |-> !acc_fault_o && acc_default_o)
        else $error("privileged miss faulted with default map");
    empty_map_a: assert property (acc_valid_i && st_r.glb_en && !st_r.priv_def
        && !acc_handler_i && st_r.ren == '0 |-> acc_fault_o)
        else $error("no enabled region yet no fault");
    fault_sticky_a: assert property (ce_i && acc_fault_o |=> st_r.fault
        && st_r.faddr == $past(acc_addr_i))
        else $error("fault not captured");
    count_read_a: assert property (wb_ack_o && $past(adr) == `MRP_ADR_COUNT
        |-> wb_dat_o == 32'(REGIONS))
        else $error("region count read wrong");
    attr_enable_a: assert property (wb_ack_o && $past(adr) == `MRP_ADR_ATTR
        && $past(sel_ok) |-> wb_dat_o[`MRP_ATTR_EN] == $past(st_r.ren[st_r.sel]))
        else $error("attribute readback lost enable");
    ren_keeps_a: assert property (ce_i && wr && adr == `MRP_ADR_REN
        |=> $stable(st_r.base) && $stable(st_r.size) && $stable(st_r.ap) && $stable(st_r.srd))
        else $error("region enable write changed config");
    size_floor_a: assert property (wb_ack_o && $past(adr) == `MRP_ADR_ATTR
        && $past(sel_ok) |-> wb_dat_o[`MRP_ATTR_SZ_HI:`MRP_ATTR_SZ_LO] >= `MRP_SIZE_MIN)
        else $error("size below 32 bytes");
    ack_pulse_a: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
        else $error("ack held two cycles");

    // fetch needs the no-execute bit clear in the deciding region
    xn_fetch_a: assert property (acc_valid_i && !acc_default_o && any_hit
        && acc_type_i == MRP_ACC_FETCH && st_r.xn[hit_idx] |-> acc_fault_o)
        else $error("fetch from no-execute region allowed");
    // an access that no enabled region matches faults unless mapped by default
    miss_faults_a: assert property (acc_valid_i && !acc_default_o && !any_hit |-> acc_fault_o)
        else $error("unmatched access did not fault");
    // a fault is only flagged while an access is presented
    fault_needs_access_a: assert property (!acc_valid_i |-> !acc_fault_o)
        else $error("fault without access");
    // clock enable low holds every register
    ce_freeze_a: assert property (!ce_i |=> $stable(st_r))
        else $error("state moved while clock enable low");
endmodule

// ---- sim/mrp_core_model.sv ----
// processor core model that presents accesses to the protection unit
`timescale 1ns/100ps
module mrp_core_model
    import mrp_pkg::*;
(
    input wire logic clk_i,
    input wire logic fault_i,
    input wire logic default_i,
    output logic valid_o,
    output logic [31:0] addr_o,
    output mrp_acc_type type_o,
    output logic priv_o,
    output logic handler_o
);
    // idle bus at time zero
    initial begin
        valid_o = 1'h0;
        addr_o = 32'h0;
        type_o = MRP_ACC_READ;
        priv_o = 1'h0;
        handler_o = 1'h0;
    end
    // one access: launched after an edge, judged while it stands
    task automatic access(input logic [31:0] a, input mrp_acc_type t, input logic p,
        input logic h, output logic f, output logic d);
        @(posedge clk_i);
        valid_o <= 1'h1;
        addr_o <= a;
        type_o <= t;
        priv_o <= p;
        handler_o <= h;
        @(negedge clk_i);
        f = fault_i;
        d = default_i;
        @(posedge clk_i);
        valid_o <= 1'h0;
        // a released address bus shows the inverse of its last value
        addr_o <= ~a;
    endtask
endmodule

// ---- sim/testbench.sv ----
// self-checking bench for the region protection unit
`timescale 1ns/100ps
`include "mrp_defines.svh"
module testbench;
    import mrp_pkg::*;
    localparam int NREG = 8;
    // bench side of the register bus
    logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [3:0] byte_en = 4'hF; // byte enables of the next bus cycle
    // access side, driven by the core model
    logic acc_valid_i, acc_priv_i, acc_handler_i, acc_fault_o, acc_default_o;
    logic [31:0] acc_addr_i;
    mrp_acc_type acc_type_i;
    // counters of the run
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    // clock of 50 ns period
    initial begin
        clk_i = 1'h0;
        forever #25 clk_i = ~clk_i;
    end
    mrp_top #(.REGIONS(NREG)) mrp_top_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .acc_valid_i(acc_valid_i), .acc_addr_i(acc_addr_i), .acc_type_i(acc_type_i),
        .acc_priv_i(acc_priv_i), .acc_handler_i(acc_handler_i), .acc_fault_o(acc_fault_o),
        .acc_default_o(acc_default_o));
    mrp_core_model mrp_core_model_inst (.clk_i(clk_i), .fault_i(acc_fault_o),
        .default_i(acc_default_o), .valid_o(acc_valid_i), .addr_o(acc_addr_i),
        .type_o(acc_type_i), .priv_o(acc_priv_i), .handler_o(acc_handler_i));
    // verdict and end of run
    task automatic complete_run();
        if (num_errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // compare of a word
    task automatic check_word(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask
    // compare of a flag
    task automatic check_bit(input string n, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s: expected %b, seen %b", n, e, g);
        end
    endtask
    // one classic cycle, held until ack is sampled at a rising edge
    task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= byte_en;
        wb_dat_i <= d;
        // this wait ends when ack is seen; the hang guard stops it if ack never comes
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'h1);
        // ack stands in the cycle after the request is taken
        check_word("ack wait", 32'h2, 32'(n));
        rd = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        wb_we_i <= 1'h0;
    endtask
    // register write
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb_xfer(1'h1, a, d);
    endtask
    // register read with expected value
    task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
        wb_xfer(1'h0, a, 32'h0);
        check_word(n, e, rd);
    endtask
    // one access with expected fault and default map flags
    task automatic acc(input logic [31:0] a, input mrp_acc_type t, input logic p,
        input logic h, input logic ef, input logic ed);
        logic f, d;
        mrp_core_model_inst.access(a, t, p, h, f, d);
        check_bit("fault", ef, f);
        check_bit("default", ed, d);
    endtask
    // attribute word from its fields
    function automatic logic [31:0] mk_attr(input logic en, input logic [4:0] sz,
        input logic [7:0] srd, input logic [2:0] ap, input logic xn);
        mk_attr = {3'h0, xn, 1'h0, ap, 8'h00, srd, 2'h0, sz, en};
    endfunction
    // expected permission per code, mode and direction
    function automatic logic perm_ok(input logic [2:0] ap, input logic p, input logic w);
        case (ap)
            `MRP_AP_PRW_UNO: perm_ok = p;
            `MRP_AP_PRW_URO: perm_ok = p | !w;
            `MRP_AP_RW_RW: perm_ok = 1'h1;
            `MRP_AP_PRO_UNO: perm_ok = p & !w;
            `MRP_AP_RO_RO: perm_ok = !w;
            default: perm_ok = 1'h0;
        endcase
    endfunction
    // region set up, held off while its fields change
    task automatic set_region(input logic [2:0] s, input logic [31:0] b, input logic [31:0] at);
        wr(`MRP_ADR_SEL, {29'h0, s});
        wr(`MRP_ADR_ATTR, at & 32'hFFFFFFFE);
        wr(`MRP_ADR_BASE, b);
        wr(`MRP_ADR_ATTR, at);
    endtask
    // hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 6000) begin
            num_errors++;
            complete_run();
        end
    end
    // main sequence
    initial begin
        rst_i = 1'h1;
        ce_i = 1'h1;
        wb_cyc_i = 1'h0;
        wb_stb_i = 1'h0;
        wb_we_i = 1'h0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hF;
        wb_dat_i = 32'h0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'h0;
        rchk("ctrl", `MRP_ADR_CTRL, 32'h0);
        rchk("count", `MRP_ADR_COUNT, 32'(NREG));
        rchk("unmapped", 8'h20, 32'h0);
        acc(32'h1000, MRP_ACC_WRITE, 1'h0, 1'h0, 1'h0, 1'h1);
        // unit on, no region and no privileged default
        wr(`MRP_ADR_CTRL, 32'h1);
        acc(32'h1000, MRP_ACC_READ, 1'h0, 1'h0, 1'h1, 1'h0);
        acc(32'h1000, MRP_ACC_READ, 1'h1, 1'h0, 1'h1, 1'h0);
        rchk("fstat", `MRP_ADR_FSTAT, 32'h1);
        rchk("faddr", `MRP_ADR_FADDR, 32'h1000);
        wr(`MRP_ADR_FSTAT, 32'h1);
        rchk("fstat", `MRP_ADR_FSTAT, 32'h0);
        // clock enable low: a faulting access leaves no trace in the flag
        ce_i <= 1'h0;
        acc(32'h1000, MRP_ACC_READ, 1'h0, 1'h0, 1'h1, 1'h0);
        ce_i <= 1'h1;
        rchk("fstat", `MRP_ADR_FSTAT, 32'h0);
        // privileged default option
        wr(`MRP_ADR_CTRL, 32'h3);
        acc(32'h1000, MRP_ACC_FETCH, 1'h1, 1'h0, 1'h0, 1'h1);
        acc(32'h1000, MRP_ACC_READ, 1'h0, 1'h0, 1'h1, 1'h0);
        // protection inside fault handlers, off then on
        wr(`MRP_ADR_CTRL, 32'h1);
        acc(32'h1000, MRP_ACC_READ, 1'h0, 1'h1, 1'h0, 1'h1);
        wr(`MRP_ADR_CTRL, 32'h5);
        acc(32'h1000, MRP_ACC_READ, 1'h0, 1'h1, 1'h1, 1'h0);
        // unit off while the first region is programmed
        wr(`MRP_ADR_CTRL, 32'h0);
        // 8 KB region, no execute; bases are size aligned throughout
        set_region(3'h0, 32'h20000000, mk_attr(1'h1, 5'h0C, 8'h00, `MRP_AP_RW_RW, 1'h1));
        wr(`MRP_ADR_CTRL, 32'h1);
        rchk("attr", `MRP_ADR_ATTR, mk_attr(1'h1, 5'h0C, 8'h00, `MRP_AP_RW_RW, 1'h1));
        rchk("base", `MRP_ADR_BASE, 32'h20000000);
        acc(32'h20000100, MRP_ACC_FETCH, 1'h1, 1'h0, 1'h1, 1'h0);
        acc(32'h20000100, MRP_ACC_READ, 1'h0, 1'h0, 1'h0, 1'h0);
        // every permission code against fetch, read and write in both modes
        for (int ap = 0; ap < 8; ap++) begin
            set_region(3'h0, 32'h20000000, mk_attr(1'h1, 5'h0C, 8'h00, 3'(ap), 1'h0));
            for (int t = 0; t < 3; t++) begin
                for (int p = 0; p < 2; p++) begin
                    acc(32'h20000100, mrp_acc_type'(t), 1'(p), 1'h0,
                        !perm_ok(3'(ap), 1'(p), t == 2), 1'h0);
                end
            end
        end
        // sub-region 2 of region 0 disabled, then covered by region 1
        set_region(3'h0, 32'h20000000, mk_attr(1'h1, 5'h0C, 8'h04, `MRP_AP_RW_RW, 1'h0));
        acc(32'h20000900, MRP_ACC_READ, 1'h0, 1'h0, 1'h1, 1'h0);
        acc(32'h20000500, MRP_ACC_READ, 1'h0, 1'h0, 1'h0, 1'h0);
        set_region(3'h1, 32'h20000800, mk_attr(1'h1, 5'h09, 8'h00, `MRP_AP_RO_RO, 1'h0));
        acc(32'h20000900, MRP_ACC_READ, 1'h0, 1'h0, 1'h0, 1'h0);
        acc(32'h20000900, MRP_ACC_WRITE, 1'h0, 1'h0, 1'h1, 1'h0);
        // 256 B no-access region on top, first sub-region a hole
        set_region(3'h2, 32'h20000000, mk_attr(1'h1, 5'h07, 8'h01, `MRP_AP_NONE, 1'h0));
        acc(32'h20000040, MRP_ACC_READ, 1'h0, 1'h0, 1'h1, 1'h0);
        acc(32'h20000010, MRP_ACC_READ, 1'h0, 1'h0, 1'h0, 1'h0);
        // 128 B region ignores its sub-region disables
        set_region(3'h3, 32'h20000400, mk_attr(1'h1, 5'h06, 8'hFF, `MRP_AP_NONE, 1'h0));
        acc(32'h20000410, MRP_ACC_READ, 1'h0, 1'h0, 1'h1, 1'h0);
        // region enables off and on keep the configuration
        wr(`MRP_ADR_REN, 32'h3);
        acc(32'h20000040, MRP_ACC_READ, 1'h0, 1'h0, 1'h0, 1'h0);
        wr(`MRP_ADR_SEL, 32'h2);
        rchk("attr", `MRP_ADR_ATTR, mk_attr(1'h0, 5'h07, 8'h01, `MRP_AP_NONE, 1'h0));
        wr(`MRP_ADR_REN, 32'hF);
        acc(32'h20000040, MRP_ACC_READ, 1'h0, 1'h0, 1'h1, 1'h0);
        // smallest size clamps, largest covers the whole space
        wr(`MRP_ADR_SEL, 32'h4);
        wr(`MRP_ADR_ATTR, mk_attr(1'h0, 5'h02, 8'h00, `MRP_AP_NONE, 1'h0));
        rchk("attr", `MRP_ADR_ATTR, mk_attr(1'h0, 5'h04, 8'h00, `MRP_AP_NONE, 1'h0));
        // byte lane 1 alone: only the sub-region disables change
        byte_en = 4'h2;
        wr(`MRP_ADR_ATTR, 32'hFFFFFFFF);
        byte_en = 4'hF;
        rchk("attr", `MRP_ADR_ATTR, mk_attr(1'h0, 5'h04, 8'hFF, `MRP_AP_NONE, 1'h0));
        set_region(3'h7, 32'h0, mk_attr(1'h1, 5'h1F, 8'h00, `MRP_AP_RW_RW, 1'h0));
        acc(32'hF0000000, MRP_ACC_WRITE, 1'h0, 1'h0, 1'h0, 1'h0);
        acc(32'h20000040, MRP_ACC_WRITE, 1'h0, 1'h0, 1'h0, 1'h0);
        // unit off with regions programmed
        wr(`MRP_ADR_CTRL, 32'h0);
        acc(32'h20000410, MRP_ACC_READ, 1'h0, 1'h0, 1'h0, 1'h1);
        complete_run();
    end
endmodule
